// ### fspi_pkg.sv
// Shared constants for the serial flash read and identification link.
// Assumes a 10 MHz system clock at both ends of the link.
package fspi_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Opcodes
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST = 8'h0b;
  localparam logic [7:0] OP_DUAL = 8'h3b;
  localparam logic [7:0] OP_SLEEP = 8'hb9;
  localparam logic [7:0] OP_WAKE = 8'hab;
  localparam logic [7:0] OP_MFDEV = 8'h90;
  localparam logic [7:0] OP_IDENT = 8'h9f;
  localparam logic [7:0] OP_UID = 8'h4b;

  ////////////////////////////////////////////////////////////////////////////
  // Frame layout
  localparam int ADDR_W = 24;
  localparam logic [5:0] OPC_LAST = 6'h07;
  localparam logic [5:0] ADDR_LAST = 6'h17;
  localparam logic [5:0] DUMMY_LAST = 6'h07;
  localparam logic [5:0] OPC_BITS = 6'h08;
  localparam logic [5:0] ADDR_BITS = 6'h18;
  localparam logic [5:0] DUMMY_BITS = 6'h08;
  localparam logic [3:0] SINGLE_LAST = 4'h7;
  localparam logic [3:0] DUAL_LAST = 4'h3;
  localparam logic [3:0] IDENT_LAST = 4'h2;
  localparam logic [3:0] UID_LAST = 4'hf;

  ////////////////////////////////////////////////////////////////////////////
  // Identification values, all arbitrary
  localparam logic [7:0] MFR_ID = 8'h5a;
  localparam logic [7:0] DEV_ID = 8'h13;
  localparam logic [7:0] MEM_TYPE = 8'h40;
  localparam logic [7:0] CAPACITY = 8'h14;
  localparam logic [127:0] UNIQUE_ID =
    128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_NS = 100;
  localparam int LINK_HALF_NS = 400;
  localparam int SLEEP_ENTRY_NS = 3000;
  localparam int WAKE_PLAIN_NS = 3000;
  localparam int WAKE_IDENT_NS = 1800;
  localparam int CS_GAP_NS = 400;
  localparam int TMR_W = 16;
  localparam logic [3:0] LINK_HALF_CYC = 4'(LINK_HALF_NS / CLK_NS);
  // Device side: longest times, rounded down
  localparam logic [TMR_W-1:0] SLEEP_ENTRY_CYC =
    TMR_W'(SLEEP_ENTRY_NS / CLK_NS);
  localparam logic [TMR_W-1:0] WAKE_PLAIN_CYC =
    TMR_W'(WAKE_PLAIN_NS / CLK_NS);
  localparam logic [TMR_W-1:0] WAKE_IDENT_CYC =
    TMR_W'(WAKE_IDENT_NS / CLK_NS);
  // Device side: cycles from a pin change to its detected edge
  localparam logic [TMR_W-1:0] SYNC_LAG_CYC = TMR_W'(3);
  // Host side: least hold times, rounded up
  localparam logic [TMR_W-1:0] HOLD_ENTRY_CYC =
    TMR_W'((SLEEP_ENTRY_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TMR_W-1:0] HOLD_PLAIN_CYC =
    TMR_W'((WAKE_PLAIN_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TMR_W-1:0] HOLD_IDENT_CYC =
    TMR_W'((WAKE_IDENT_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TMR_W-1:0] HOLD_GAP_CYC =
    TMR_W'((CS_GAP_NS + CLK_NS - 1) / CLK_NS);

endpackage

// ### fspi_link_if.sv
// Four-wire serial flash link between host controller and flash device.
// Assumes pull-ups on both data wires when neither end drives them.
`timescale 1ns/100ps
interface fspi_link_if;
  logic cs_n;
  logic sclk;
  logic host_io0_o;
  logic host_io0_oe;
  logic dev_io0_o;
  logic dev_io0_oe;
  logic dev_io1_o;
  logic dev_io1_oe;
  logic io0;
  logic io1;

  // Wire levels resolved from the enables
  assign io0 = host_io0_oe ? host_io0_o : (dev_io0_oe ? dev_io0_o : 1'b1);
  assign io1 = dev_io1_oe ? dev_io1_o : 1'b1;

  modport host (
    output cs_n,
    output sclk,
    output host_io0_o,
    output host_io0_oe,
    input io0,
    input io1
  );

  modport dev (
    input cs_n,
    input sclk,
    input io0,
    output dev_io0_o,
    output dev_io0_oe,
    output dev_io1_o,
    output dev_io1_oe
  );
endinterface

// ### fspi_dev.sv
// Flash device end: read, identification and deep sleep command handling.
// Assumes an external array answering rd_addr with rd_data within a cycle
// and an external program/erase engine reporting busy.
`timescale 1ns/100ps

// Operation
// - Read 03h: opcode, 24-bit address, sampled rising
// - Data bytes out on falling edges, MSB first
// - Address increments per byte until chip select high
// - Plain read ignored while busy
// - Fast read 0Bh: address plus eight dummy clocks
// - Dual read 3Bh: two bits per clock
// - Host releases data-in before first dual output
// - Sleep B9h runs only if cs rises after eighth bit
// - Sleep entered within entry delay after cs rise
// - Asleep: only ABh recognised, all else ignored
// - Power-up starts awake in standby
// - Plain ABh wakes after first wake delay
// - ABh with three dummy bytes repeats device ID
// - ID read wakes after second wake delay
// - ABh ignored while busy
// - 90h alternates manufacturer and device ID, address-led
// - 9Fh gives manufacturer, type, capacity bytes
// - 4Bh: zero address, dummy byte, 128-bit ID
// - Busy flag high throughout self-timed cycles
module fspi_dev
  import fspi_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  fspi_link_if.dev link,
  input wire logic busy,
  output logic [ADDR_W-1:0] rd_addr,
  input wire logic [7:0] rd_data,
  output logic asleep
);

  typedef enum logic [2:0] {
    FSPI_CMD, FSPI_OPEND, FSPI_ADDR, FSPI_DUMMY, FSPI_DATA, FSPI_IGNORE
  } fspi_dst_t;

  typedef enum logic [1:0] {
    FSPI_TNONE, FSPI_TENTER, FSPI_TWAKE
  } fspi_tmode_t;

  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic cs_prev;
    logic ck_s1;
    logic ck_s2;
    logic ck_prev;
    logic d_s1;
    logic d_s2;
    fspi_dst_t st;
    logic [7:0] op;
    logic [5:0] cnt;
    logic [ADDR_W-1:0] addr;
    logic [7:0] osr;
    logic [3:0] obit;
    logic [3:0] idx;
    logic o1;
    logic oe1;
    logic o0;
    logic oe0;
    logic sleep;
    fspi_tmode_t tmode;
    logic [TMR_W-1:0] tmr;
  } fspi_dstate_t;

  fspi_dstate_t s_ff;
  fspi_dstate_t nxt_s;

  ////////////////////////////////////////////////////////////////////////////
  // Byte source for the data phase

  function automatic logic [7:0] fspi_pick(
    input logic [7:0] op,
    input logic [3:0] idx,
    input logic [7:0] mem
  );
    logic [7:0] b;
    b = mem;
    unique case (op)
      OP_WAKE: b = DEV_ID;
      OP_MFDEV: b = idx[0] ? DEV_ID : MFR_ID;
      OP_IDENT: begin
        if (idx == 4'h0) begin
          b = MFR_ID;
        end else if (idx == 4'h1) begin
          b = MEM_TYPE;
        end else begin
          b = CAPACITY;
        end
      end
      OP_UID: b = 8'(UNIQUE_ID >> (8 * (UID_LAST - idx)));
      default: b = mem;
    endcase
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic rise;
    logic fall;
    logic cs_up;
    logic dozing;
    logic ign;
    logic [7:0] nop;
    logic [7:0] b;
    rise = 1'b0;
    fall = 1'b0;
    cs_up = 1'b0;
    dozing = 1'b0;
    ign = 1'b0;
    nop = 8'h00;
    b = 8'h00;
    nxt_s = s_ff;
    nxt_s.cs_s1 = link.cs_n;
    nxt_s.cs_s2 = s_ff.cs_s1;
    nxt_s.cs_prev = s_ff.cs_s2;
    nxt_s.ck_s1 = link.sclk;
    nxt_s.ck_s2 = s_ff.ck_s1;
    nxt_s.ck_prev = s_ff.ck_s2;
    nxt_s.d_s1 = link.io0;
    nxt_s.d_s2 = s_ff.d_s1;
    rise = s_ff.ck_s2 & ~s_ff.ck_prev;
    fall = ~s_ff.ck_s2 & s_ff.ck_prev;
    cs_up = s_ff.cs_s2 & ~s_ff.cs_prev;
    dozing = s_ff.sleep | (s_ff.tmode != FSPI_TNONE);

    // Sleep entry and wake timers
    if (s_ff.tmr != '0) begin
      nxt_s.tmr = s_ff.tmr - 1'b1;
      if (s_ff.tmr == TMR_W'(1)) begin
        nxt_s.sleep = (s_ff.tmode == FSPI_TENTER);
        nxt_s.tmode = FSPI_TNONE;
      end
    end

    if (s_ff.cs_s2) begin
      if (cs_up) begin
        if (s_ff.st == FSPI_OPEND && s_ff.op == OP_SLEEP) begin
          nxt_s.tmode = FSPI_TENTER;
          nxt_s.tmr = SLEEP_ENTRY_CYC - SYNC_LAG_CYC;
        end
        if (s_ff.st == FSPI_OPEND && s_ff.op == OP_WAKE && s_ff.sleep) begin
          nxt_s.tmode = FSPI_TWAKE;
          nxt_s.tmr = WAKE_PLAIN_CYC - SYNC_LAG_CYC;
        end
        if (s_ff.st == FSPI_DATA && s_ff.op == OP_WAKE && s_ff.sleep) begin
          nxt_s.tmode = FSPI_TWAKE;
          nxt_s.tmr = WAKE_IDENT_CYC - SYNC_LAG_CYC;
        end
      end
      // Frame ends: outputs released, read stream stops
      nxt_s.st = FSPI_CMD;
      nxt_s.cnt = '0;
      nxt_s.oe0 = 1'b0;
      nxt_s.oe1 = 1'b0;
    end else if (rise) begin
      unique case (s_ff.st)
        FSPI_CMD: begin
          nop = {s_ff.op[6:0], s_ff.d_s2};
          nxt_s.op = nop;
          nxt_s.cnt = s_ff.cnt + 1'b1;
          if (s_ff.cnt == OPC_LAST) begin
            nxt_s.cnt = '0;
            ign = dozing && (nop != OP_WAKE);
            ign = ign || (s_ff.tmode == FSPI_TWAKE);
            if (busy && (nop == OP_READ || nop == OP_FAST ||
                nop == OP_DUAL)) begin
              ign = 1'b1;
            end
            if (busy && nop == OP_WAKE) begin
              ign = 1'b1;
            end
            unique case (nop)
              OP_SLEEP, OP_WAKE: nxt_s.st = FSPI_OPEND;
              OP_READ, OP_FAST, OP_DUAL, OP_MFDEV, OP_UID: begin
                nxt_s.st = FSPI_ADDR;
              end
              OP_IDENT: begin
                nxt_s.st = FSPI_DATA;
                nxt_s.idx = '0;
                nxt_s.obit = '0;
              end
              default: ign = 1'b1;
            endcase
            if (ign) begin
              nxt_s.st = FSPI_IGNORE;
            end
          end
        end
        FSPI_OPEND: begin
          if (s_ff.op == OP_WAKE) begin
            nxt_s.st = FSPI_ADDR;
            nxt_s.cnt = 6'h01;
          end else begin
            nxt_s.st = FSPI_IGNORE;
          end
        end
        FSPI_ADDR: begin
          nxt_s.addr = {s_ff.addr[ADDR_W-2:0], s_ff.d_s2};
          nxt_s.cnt = s_ff.cnt + 1'b1;
          if (s_ff.cnt == ADDR_LAST) begin
            nxt_s.cnt = '0;
            nxt_s.obit = '0;
            nxt_s.idx = {3'h0, s_ff.d_s2};
            if (s_ff.op == OP_FAST || s_ff.op == OP_DUAL ||
                s_ff.op == OP_UID) begin
              nxt_s.st = FSPI_DUMMY;
            end else begin
              nxt_s.st = FSPI_DATA;
            end
            if (s_ff.op == OP_UID) begin
              nxt_s.idx = '0;
            end
          end
        end
        FSPI_DUMMY: begin
          nxt_s.cnt = s_ff.cnt + 1'b1;
          if (s_ff.cnt == DUMMY_LAST) begin
            nxt_s.st = FSPI_DATA;
          end
        end
        FSPI_DATA, FSPI_IGNORE: begin
        end
      endcase
    end else if (fall && s_ff.st == FSPI_DATA) begin
      nxt_s.oe1 = 1'b1;
      if (s_ff.op == OP_DUAL) begin
        nxt_s.oe0 = 1'b1;
      end
      if (s_ff.obit == '0) begin
        b = fspi_pick(s_ff.op, s_ff.idx, rd_data);
        nxt_s.o1 = b[7];
        nxt_s.addr = s_ff.addr + 1'b1;
        nxt_s.idx = s_ff.idx + 1'b1;
        if (s_ff.op == OP_IDENT && s_ff.idx == IDENT_LAST) begin
          nxt_s.idx = '0;
        end
        if (s_ff.op == OP_DUAL) begin
          nxt_s.o0 = b[6];
          nxt_s.osr = {b[5:0], 2'b00};
          nxt_s.obit = DUAL_LAST;
        end else begin
          nxt_s.osr = {b[6:0], 1'b0};
          nxt_s.obit = SINGLE_LAST;
        end
      end else begin
        nxt_s.o1 = s_ff.osr[7];
        nxt_s.obit = s_ff.obit - 1'b1;
        if (s_ff.op == OP_DUAL) begin
          nxt_s.o0 = s_ff.osr[6];
          nxt_s.osr = {s_ff.osr[5:0], 2'b00};
        end else begin
          nxt_s.osr = {s_ff.osr[6:0], 1'b0};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign link.dev_io1_o = s_ff.o1;
  assign link.dev_io1_oe = s_ff.oe1;
  assign link.dev_io0_o = s_ff.o0;
  assign link.dev_io0_oe = s_ff.oe0;
  assign rd_addr = s_ff.addr;
  assign asleep = s_ff.sleep;

endmodule

// ### fspi_host.sv
// Host controller end: frames one command, streams read bytes out.
// Assumes the user drains rd_data; a full buffer pauses the link clock.
`timescale 1ns/100ps
module fspi_host
  import fspi_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  fspi_link_if.host link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_op,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [15:0] cmd_len,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [7:0] rd_data
);

  typedef enum logic [1:0] {
    FSPI_IDLE, FSPI_LOW, FSPI_HIGH, FSPI_HOLD
  } fspi_hst_t;

  typedef struct packed {
    fspi_hst_t st;
    logic cs_n;
    logic sclk;
    logic io0_o;
    logic io0_oe;
    logic d0_s1;
    logic d0_s2;
    logic d1_s1;
    logic d1_s2;
    logic [7:0] op;
    logic dual;
    logic with_id;
    logic [31:0] tx;
    logic [5:0] txn;
    logic [15:0] rxn;
    logic [7:0] rsh;
    logic [3:0] rbit;
    logic [3:0] ph;
    logic [TMR_W-1:0] hold;
    logic [7:0] b0;
    logic [7:0] b1;
    logic [1:0] cnt;
  } fspi_hstate_t;

  fspi_hstate_t s_ff;
  fspi_hstate_t nxt_s;

  always_comb begin
    logic pop;
    logic [7:0] nb;
    logic [5:0] bits;
    pop = rd_ready && (s_ff.cnt != 2'h0);
    nb = 8'h00;
    bits = OPC_BITS;
    nxt_s = s_ff;
    nxt_s.d0_s1 = link.io0;
    nxt_s.d0_s2 = s_ff.d0_s1;
    nxt_s.d1_s1 = link.io1;
    nxt_s.d1_s2 = s_ff.d1_s1;
    if (pop) begin
      nxt_s.b0 = s_ff.b1;
      nxt_s.cnt = s_ff.cnt - 1'b1;
    end
    unique case (s_ff.st)
      FSPI_IDLE: begin
        if (cmd_valid) begin
          if (cmd_op != OP_SLEEP && cmd_op != OP_IDENT &&
              !(cmd_op == OP_WAKE && cmd_len == 16'h0000)) begin
            bits = bits + ADDR_BITS;
          end
          if (cmd_op == OP_FAST || cmd_op == OP_DUAL || cmd_op == OP_UID) begin
            bits = bits + DUMMY_BITS;
          end
          nxt_s.st = FSPI_LOW;
          nxt_s.cs_n = 1'b0;
          nxt_s.op = cmd_op;
          nxt_s.dual = (cmd_op == OP_DUAL);
          nxt_s.with_id = (cmd_len != 16'h0000);
          nxt_s.tx = {cmd_op, cmd_addr};
          nxt_s.txn = bits;
          nxt_s.rxn = cmd_len;
          nxt_s.rbit = '0;
          nxt_s.ph = '0;
          nxt_s.io0_o = cmd_op[7];
          nxt_s.io0_oe = 1'b1;
        end
      end
      FSPI_LOW: begin
        nxt_s.ph = s_ff.ph + 1'b1;
        if (s_ff.ph == LINK_HALF_CYC - 1'b1) begin
          nxt_s.ph = s_ff.ph;
          if (s_ff.txn == '0 && s_ff.rxn == '0) begin
            nxt_s.cs_n = 1'b1;
            nxt_s.st = FSPI_HOLD;
            nxt_s.hold = HOLD_GAP_CYC;
            if (s_ff.op == OP_SLEEP) begin
              nxt_s.hold = HOLD_ENTRY_CYC;
            end else if (s_ff.op == OP_WAKE) begin
              nxt_s.hold = s_ff.with_id ? HOLD_IDENT_CYC :
                HOLD_PLAIN_CYC;
            end
          end else if (s_ff.txn != '0 || nxt_s.cnt != 2'h2) begin
            nxt_s.sclk = 1'b1;
            nxt_s.st = FSPI_HIGH;
            nxt_s.ph = '0;
          end
        end
      end
      FSPI_HIGH: begin
        nxt_s.ph = s_ff.ph + 1'b1;
        if (s_ff.ph == LINK_HALF_CYC - 1'b1) begin
          nxt_s.sclk = 1'b0;
          nxt_s.st = FSPI_LOW;
          nxt_s.ph = '0;
          if (s_ff.txn != '0) begin
            nxt_s.txn = s_ff.txn - 1'b1;
            nxt_s.tx = {s_ff.tx[30:0], 1'b0};
            nxt_s.io0_o = s_ff.tx[30];
            if (s_ff.txn == 6'h01) begin
              nxt_s.io0_oe = 1'b0;
            end
          end else begin
            if (s_ff.dual) begin
              nb = {s_ff.rsh[5:0], s_ff.d1_s2, s_ff.d0_s2};
            end else begin
              nb = {s_ff.rsh[6:0], s_ff.d1_s2};
            end
            nxt_s.rsh = nb;
            nxt_s.rbit = s_ff.rbit + 1'b1;
            if (s_ff.rbit == (s_ff.dual ? DUAL_LAST : SINGLE_LAST)) begin
              nxt_s.rbit = '0;
              nxt_s.rxn = s_ff.rxn - 1'b1;
              if (nxt_s.cnt == 2'h0) begin
                nxt_s.b0 = nb;
              end else begin
                nxt_s.b1 = nb;
              end
              nxt_s.cnt = nxt_s.cnt + 1'b1;
            end
          end
        end
      end
      FSPI_HOLD: begin
        nxt_s.hold = s_ff.hold - 1'b1;
        if (s_ff.hold == TMR_W'(1)) begin
          nxt_s.st = FSPI_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_ff <= '0;
      s_ff.cs_n <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign cmd_ready = (s_ff.st == FSPI_IDLE);
  assign rd_valid = (s_ff.cnt != 2'h0);
  assign rd_data = s_ff.b0;
  assign link.cs_n = s_ff.cs_n;
  assign link.sclk = s_ff.sclk;
  assign link.host_io0_o = s_ff.io0_o;
  assign link.host_io0_oe = s_ff.io0_oe;

endmodule

// ### fspi_props.sv
// Concurrent checks on the four-wire flash link between host and device.
// Assumes both link ends share clk and the synchronous reset_n.
`timescale 1ns/100ps
module fspi_props (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic host_io0_o,
  input wire logic host_io0_oe,
  input wire logic dev_io0_o,
  input wire logic dev_io0_oe,
  input wire logic dev_io1_o,
  input wire logic dev_io1_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  ///////////////////////////////////////////////////////////////////////////
  // Sequences and properties
  sequence s_high_phase;
    sclk[*4] ##1 !sclk;
  endsequence

  sequence s_cs_hold;
    cs_n[*4];
  endsequence

  property p_idle_after_reset;
    $rose(reset_n) |-> cs_n && !sclk && !host_io0_oe && !dev_io1_oe;
  endproperty
  property p_cs_idle_clock_low;
    cs_n |-> !sclk;
  endproperty
  property p_high_phase;
    $rose(sclk) |-> s_high_phase;
  endproperty
  property p_host_tx_stable;
    sclk && $past(sclk) && host_io0_oe |-> $stable(host_io0_o);
  endproperty
  property p_dev_tx_stable;
    sclk && $past(sclk) && dev_io1_oe |->
      $stable(dev_io1_o) && (!dev_io0_oe || $stable(dev_io0_o));
  endproperty
  property p_no_contention;
    !(host_io0_oe && dev_io0_oe);
  endproperty
  property p_dual_pair;
    dev_io0_oe |-> dev_io1_oe;
  endproperty
  property p_release_after_cs;
    cs_n[*6] |-> !dev_io1_oe && !dev_io0_oe;
  endproperty
  property p_frame_gap;
    $rose(cs_n) |-> s_cs_hold;
  endproperty
  property p_cs_fall_start;
    $fell(cs_n) |-> host_io0_oe && !sclk;
  endproperty

  ///////////////////////////////////////////////////////////////////////////
  // Assertions
  a_idle_after_reset: assert property (p_idle_after_reset)
    else $error("link not idle after reset");
  a_cs_idle_clock_low: assert property (p_cs_idle_clock_low)
    else $error("clock high while deselected");
  a_high_phase: assert property (p_high_phase)
    else $error("clock high phase not four cycles");
  a_host_tx_stable: assert property (p_host_tx_stable)
    else $error("host data moved while clock high");
  a_dev_tx_stable: assert property (p_dev_tx_stable)
    else $error("device data moved while clock high");
  a_no_contention: assert property (p_no_contention)
    else $error("both ends drive io0");
  a_dual_pair: assert property (p_dual_pair)
    else $error("io0 driven without io1");
  a_release_after_cs: assert property (p_release_after_cs)
    else $error("device drives while deselected");
  a_frame_gap: assert property (p_frame_gap)
    else $error("chip select high too short");
  a_cs_fall_start: assert property (p_cs_fall_start)
    else $error("frame start without host drive");
endmodule

// ### spi_flash_read_id_powerdown_tb_top.sv
// Self-checking bench: host and device joined by one link, plus a second
// device driven bit by bit. Assumes fspi_pkg and fspi_link_if compiled.
`timescale 1ns/100ps
module spi_flash_read_id_powerdown_tb_top;
  import fspi_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_ready;
  logic [7:0] cmd_op = 8'h00;
  logic [ADDR_W-1:0] cmd_addr = 24'h00_0000;
  logic [15:0] cmd_len = 16'h0000;
  logic rd_valid;
  logic rd_ready = 1'b0;
  logic [7:0] rd_data;
  logic busy = 1'b0;
  logic [ADDR_W-1:0] rd_addr;
  logic [7:0] mem_data;
  logic asleep;
  logic asleep_b;
  logic [31:0] seed = 32'h0000_1304;
  logic cs_q = 1'b1;
  logic sclk_q = 1'b0;
  logic sleep_exp = 1'b0;
  logic [7:0] rops [7] = '{OP_READ, OP_FAST, OP_DUAL, OP_MFDEV, OP_IDENT,
    OP_UID, OP_WAKE};
  int failures = 0;
  int n_tests = 0;
  int n_rise = 0;

  fspi_link_if link();
  fspi_link_if link_b();

  ///////////////////////////////////////////////////////////////////////////
  // Expectations
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [7:0] mem_byte(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5c;
  endfunction

  function automatic logic [7:0] exp_byte(input logic [7:0] op,
    input logic [23:0] a, input int i);
    if ((sleep_exp && op != OP_WAKE) || (busy && (op == OP_READ ||
        op == OP_FAST || op == OP_DUAL || op == OP_WAKE)))
      return 8'hff;
    case (op)
      OP_MFDEV: return ((i + int'(a[0])) % 2 == 0) ? MFR_ID : DEV_ID;
      OP_IDENT: return (i % 3 == 0) ? MFR_ID : (i % 3 == 1) ? MEM_TYPE :
        CAPACITY;
      OP_UID: return UNIQUE_ID[127 - 8 * (i % 16) -: 8];
      OP_WAKE: return DEV_ID;
      default: return mem_byte(a + 24'(i));
    endcase
  endfunction

  function automatic int exp_rise(input logic [7:0] op, input int n);
    case (op)
      OP_SLEEP: return 8;
      OP_WAKE: return (n > 0) ? 32 + 8 * n : 8;
      OP_IDENT: return 8 + 8 * n;
      OP_READ, OP_MFDEV: return 32 + 8 * n;
      OP_DUAL: return 40 + 4 * n;
      default: return 40 + 8 * n;
    endcase
  endfunction

  ///////////////////////////////////////////////////////////////////////////
  // Design and checker
  assign mem_data = mem_byte(rd_addr);
  always #50 clk = ~clk;

  fspi_host u_fspi_host (.clk(clk), .reset_n(reset_n), .link(link),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_len(cmd_len), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_data(rd_data));
  fspi_dev u_fspi_dev (.clk(clk), .reset_n(reset_n), .link(link),
    .busy(busy), .rd_addr(rd_addr), .rd_data(mem_data), .asleep(asleep));
  fspi_dev u_fspi_dev_b (.clk(clk), .reset_n(reset_n), .link(link_b),
    .busy(1'b0), .rd_addr(), .rd_data(8'h00), .asleep(asleep_b));
  fspi_props u_fspi_props (.clk(clk), .reset_n(reset_n), .cs_n(link.cs_n),
    .sclk(link.sclk), .host_io0_o(link.host_io0_o),
    .host_io0_oe(link.host_io0_oe), .dev_io0_o(link.dev_io0_o),
    .dev_io0_oe(link.dev_io0_oe), .dev_io1_o(link.dev_io1_o),
    .dev_io1_oe(link.dev_io1_oe));

  // Counts link clock rises per frame
  always @(posedge clk) begin
    cs_q <= link.cs_n;
    sclk_q <= link.sclk;
    if (cs_q && !link.cs_n)
      n_rise <= 0;
    else if (link.sclk && !sclk_q)
      n_rise <= n_rise + 1;
  end

  ///////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic run_cmd(input logic [7:0] op, input logic [23:0] a,
    input int n);
    int i;
    int k;
    i = 0;
    k = 0;
    @(negedge clk);
    cmd_op = op;
    cmd_addr = a;
    cmd_len = 16'(n);
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1 && k < 5000) begin
      @(negedge clk);
      k++;
    end
    @(negedge clk);
    cmd_valid = 1'b0;
    while (i < n && k < 20000) begin
      rd_ready = (rnd() % 4 != 0);
      if (rd_ready && rd_valid === 1'b1) begin
        chk(32'(rd_data), 32'(exp_byte(op, a, i)));
        i++;
      end
      k++;
      @(negedge clk);
    end
    rd_ready = 1'b0;
    while (cmd_ready !== 1'b1 && k < 40000) begin
      @(negedge clk);
      k++;
    end
    if (i < n || cmd_ready !== 1'b1) begin
      failures++;
      $display("unexpected at %0t: command timed out", $time);
    end
    chk(32'(n_rise), 32'(exp_rise(op, n)));
    $display("test op %h addr %h len %0d ended", op, a, n);
  endtask

  // Bit-level frame on the second link, extra clocks after the opcode
  task automatic bb_frame(input logic [7:0] op, input int extra);
    int i;
    @(negedge clk);
    link_b.cs_n = 1'b0;
    link_b.host_io0_oe = 1'b1;
    for (i = 0; i < 8 + extra; i++) begin
      link_b.host_io0_o = (i < 8) ? op[7 - i] : 1'b0;
      repeat (4) @(negedge clk);
      link_b.sclk = 1'b1;
      repeat (4) @(negedge clk);
      link_b.sclk = 1'b0;
    end
    link_b.host_io0_oe = 1'b0;
    repeat (4) @(negedge clk);
    link_b.cs_n = 1'b1;
    repeat (40) @(negedge clk);
  endtask

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  ///////////////////////////////////////////////////////////////////////////
  // Sequence
  initial begin
    #(CLK_NS * 60000);
    failures++;
    $display("unexpected at %0t: watchdog expired", $time);
    print_verdict();
  end

  initial begin
    int j;
    logic [7:0] op;
    logic [23:0] a;
    link_b.cs_n = 1'b1;
    link_b.sclk = 1'b0;
    link_b.host_io0_o = 1'b0;
    link_b.host_io0_oe = 1'b0;
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    chk(32'(asleep), 32'h0000_0000);
    run_cmd(OP_READ, 24'hff_fffe, 4);
    run_cmd(OP_FAST, 24'h01_2345, 3);
    run_cmd(OP_DUAL, 24'h00_fffd, 5);
    run_cmd(OP_MFDEV, 24'h00_0000, 3);
    run_cmd(OP_MFDEV, 24'h00_0001, 3);
    run_cmd(OP_IDENT, 24'h00_0000, 4);
    run_cmd(OP_UID, 24'h00_0000, 17);
    run_cmd(OP_WAKE, 24'h00_0000, 3);
    busy = 1'b1;
    run_cmd(OP_READ, 24'h00_0040, 2);
    run_cmd(OP_WAKE, 24'h00_0000, 2);
    run_cmd(OP_IDENT, 24'h00_0000, 3);
    busy = 1'b0;
    run_cmd(OP_SLEEP, 24'h00_0000, 0);
    sleep_exp = 1'b1;
    chk(32'(asleep), 32'h0000_0001);
    run_cmd(OP_IDENT, 24'h00_0000, 3);
    run_cmd(OP_DUAL, 24'h00_0100, 2);
    run_cmd(OP_WAKE, 24'h00_0000, 0);
    sleep_exp = 1'b0;
    chk(32'(asleep), 32'h0000_0000);
    run_cmd(OP_READ, 24'h00_0200, 2);
    run_cmd(OP_SLEEP, 24'h00_0000, 0);
    sleep_exp = 1'b1;
    run_cmd(OP_WAKE, 24'h00_0000, 2);
    sleep_exp = 1'b0;
    chk(32'(asleep), 32'h0000_0000);
    for (j = 0; j < 20; j++) begin
      op = rops[rnd() % 7];
      a = 24'(rnd() >> 8);
      if (op == OP_UID)
        a = 24'h00_0000;
      if (op == OP_MFDEV)
        a = {23'h00_0000, a[0]};
      busy = (rnd() % 8 == 0);
      run_cmd(op, a, 1 + int'(rnd() % 6));
    end
    busy = 1'b0;
    bb_frame(OP_SLEEP, 1);
    chk(32'(asleep_b), 32'h0000_0000);
    bb_frame(OP_SLEEP, 0);
    chk(32'(asleep_b), 32'h0000_0001);
    bb_frame(OP_WAKE, 0);
    chk(32'(asleep_b), 32'h0000_0000);
    $display("test bit level sleep framing ended");
    print_verdict();
  end
endmodule
